// [logic/cam_threshold_update.sv]
// Running-mode switch-point generator with classic Wishbone registers.
// Assumes field_sample is synchronous to clk and the output pin is pulled up outside.
//
// Functional notes
// [R1] Two polarities: low on tooth and high on valley, or the inverse.
// [R2] Positive peak memory depth is programmable from one to twelve teeth.
// [R3] Operate and release levels are percent of peak-to-peak; 30 or 50 standard.
// [R4] Custom codes place each level from 30 to 50 percent in 1.56 percent steps.
// [R5] Peak drops beyond operate minus 15 or minus 5 percent are flagged.
// [R6] Depth one bases each tooth on the previous tooth's peak.
// [R7] Depths two to twelve keep the last n peaks in a rotating store.
// [R8] Memory update uses the peak captured n teeth earlier.
// [R9] Continuous valley tracking takes the previous tooth's valley as is.
// [R10] Bounded valley tracking rejects large tooth-to-tooth valley jumps.
// [R11] Output follows only level crossings, independent of rotation direction.
// [R12] Switching uses ten percent peak-to-peak hysteresis split about both levels.
// [R13] Depth and valley style are separate fields latched before running starts.
//
// Decided for this implementation: the register addresses and register access over Wishbone.
`timescale 1ns/10ps
`default_nettype none
module cam_threshold_update
	import cam_thr_pkg::*;
(
	input  wire logic          clk,
	input  wire logic          rstn,
	input  wire logic          wb_cyc,
	input  wire logic          wb_stb,
	input  wire logic          wb_we,
	input  wire logic [7:0]    wb_adr,
	input  wire logic [3:0]    wb_sel,
	input  wire logic [31:0]   wb_dat_w,
	output var  logic [31:0]   wb_dat_r,
	output var  logic          wb_ack,
	input  wire logic [SW-1:0] field_sample,
	input  wire logic          field_valid,
	output var  logic          target_out,
	output var  logic          target_out_oe
);

	typedef struct packed {
		logic          ack;
		logic [31:0]   rdat;
		logic          run;
		logic          pol;
		logic [3:0]    depth_reg;
		logic          bound_reg;
		thr_mode_t     tmode;
		logic [3:0]    op_code;
		logic [3:0]    rel_code;
		logic          running;
		logic [3:0]    act_depth;
		logic          act_bound;
		phase_t        phase;
		logic [SW-1:0] cur_max;
		logic [SW-1:0] cur_min;
		logic [SW-1:0] valley;
		logic [SW-1:0] last_pk;
		logic          vl_valid;
		logic          pk_valid;
		logic          warn;
		logic          fail;
		logic          out_lvl;
		logic          oe;
	} core_state_t;

	localparam core_state_t CORE_RST = '{
		ack: 1'b0, rdat: '0, run: 1'b0, pol: 1'b0, depth_reg: DEPTH_RST,
		bound_reg: 1'b0, tmode: THR_STD30, op_code: CODE_RST, rel_code: CODE_RST,
		running: 1'b0, act_depth: DEPTH_RST, act_bound: 1'b0, phase: S_VALLEY,
		cur_max: '0, cur_min: '1, valley: '0, last_pk: '0, vl_valid: 1'b0,
		pk_valid: 1'b0, warn: 1'b0, fail: 1'b0, out_lvl: 1'b1, oe: 1'b0
	};

	logic [1:0]    rst_sync_ff;
	logic          rst_sync_n;
	core_state_t   q_ff;
	core_state_t   nxt_q;
	logic [SW-1:0] p2p;
	logic [SW-1:0] ref_pk;
	logic [SW-1:0] half_hys;
	logic [SW-1:0] op_lvl;
	logic [SW-1:0] rel_lvl;
	logic [SW-1:0] rel_frac;
	logic [SW-1:0] jump;
	logic [SW-1:0] drop;
	logic [SW-1:0] last_p2p;
	logic [11:0]   op_w;
	logic [11:0]   rel_w;
	logic [31:0]   wr_word;
	logic          set_warn;
	logic          set_fail;
	logic          pm_clear;
	logic          pm_push;

	peak_mem_if #(.W(SW), .DW(DEPTH_W)) pm ();

	peak_memory #(.W(SW), .DEPTH_MAX_P(DEPTH_MAX)) u_peak_memory (
		.clk   (clk),
		.rst_n (rst_sync_n),
		.pm    (pm)
	);

	assign pm.clear    = pm_clear;
	assign pm.push     = pm_push;
	assign pm.push_val = q_ff.cur_max;
	assign pm.depth    = q_ff.act_depth;

	// Share of the amplitude for a weight in 1/64 percent units
	function automatic logic [SW-1:0] frac(input logic [SW-1:0] amp, input logic [11:0] w);
		logic [SW+11:0] prod;
		prod = amp * w;
		return SW'(prod / (SW+12)'(PCT_SCALE));
	endfunction : frac

	function automatic logic [11:0] weight(input thr_mode_t m, input logic [3:0] code);
		logic [11:0] w;
		w = PCT_30;
		if (m == THR_STD50)
			w = PCT_50; // [R3]
		else if (m == THR_CUSTOM)
		begin
			// Code 13 and above would pass 50 percent, so they pin to it
			if (code > CODE_MAX)
				w = PCT_50;
			else
				w = 12'(PCT_30 + 12'(code) * PCT_STEP); // [R4]
		end
		return w;
	endfunction : weight

	function automatic logic [31:0] lanes(input logic [31:0] old, input logic [31:0] dat,
					      input logic [3:0] sel);
		logic [31:0] r;
		r = old;
		for (int i = 0; i < 4; i++)
		begin
			if (sel[i])
				r[8*i +: 8] = dat[8*i +: 8];
		end
		return r;
	endfunction : lanes

	function automatic logic [3:0] clamp_depth(input logic [3:0] d);
		logic [3:0] r;
		r = d;
		if (d == 4'h0)
			r = 4'h1;
		else if (d > 4'(DEPTH_MAX))
			r = 4'(DEPTH_MAX);
		return r;
	endfunction : clamp_depth

	function automatic logic [31:0] reg_read(input core_state_t c, input logic [7:0] a);
		logic [31:0] r;
		r = '0;
		if (a == ADDR_CTRL)
		begin
			r[CTRL_RUN_BIT]              = c.run;
			r[CTRL_POL_BIT]              = c.pol;
			r[CTRL_DEPTH_LSB +: DEPTH_W] = c.depth_reg;
			r[CTRL_BOUND_BIT]            = c.bound_reg;
		end
		else if (a == ADDR_THR)
		begin
			r[THR_MODE_LSB +: 2] = c.tmode;
			r[THR_OP_LSB +: 4]   = c.op_code;
			r[THR_REL_LSB +: 4]  = c.rel_code;
		end
		else if (a == ADDR_STATUS)
		begin
			r[ST_TOOTH_BIT] = (c.phase == S_TOOTH);
			r[ST_OUT_BIT]   = c.out_lvl;
			r[ST_WARN_BIT]  = c.warn;
			r[ST_FAIL_BIT]  = c.fail;
			r[ST_RUN_BIT]   = c.running;
		end
		else if (a == ADDR_LEVELS)
		begin
			r[LV_PEAK_LSB +: SW]   = pm.ref_val;
			r[LV_VALLEY_LSB +: SW] = c.valley;
		end
		return r;
	endfunction : reg_read

	// Switch levels for the coming edge, from the stored peak and tracked valley
	always_comb
	begin
		op_w  = weight(q_ff.tmode, q_ff.op_code);
		rel_w = weight(q_ff.tmode, q_ff.rel_code);
		ref_pk = q_ff.pk_valid ? pm.ref_val : q_ff.cur_max; // Empty history: tooth max
		if (ref_pk > q_ff.valley)
			p2p = SW'(ref_pk - q_ff.valley);
		else
			p2p = '0;
		half_hys = frac(p2p, HYS_W) >> 1; // [R12]
		op_lvl   = SW'(q_ff.valley + frac(p2p, op_w) + half_hys); // [R3]
		rel_frac = frac(p2p, rel_w);
		if (rel_frac > half_hys)
			rel_lvl = SW'(q_ff.valley + rel_frac - half_hys); // [R12]
		else
			rel_lvl = q_ff.valley;
		if (q_ff.cur_min > q_ff.valley)
			jump = SW'(q_ff.cur_min - q_ff.valley);
		else
			jump = SW'(q_ff.valley - q_ff.cur_min);
		if (q_ff.last_pk > q_ff.cur_max)
			drop = SW'(q_ff.last_pk - q_ff.cur_max);
		else
			drop = '0;
		if (q_ff.last_pk > q_ff.valley)
			last_p2p = SW'(q_ff.last_pk - q_ff.valley);
		else
			last_p2p = '0;
	end

	always_comb
	begin
		nxt_q    = q_ff;
		pm_clear = 1'b0;
		pm_push  = 1'b0;
		set_warn = 1'b0;
		set_fail = 1'b0;
		wr_word  = lanes(reg_read(q_ff, wb_adr), wb_dat_w, wb_sel);

		nxt_q.ack = 1'b0;
		if (wb_cyc && wb_stb && !q_ff.ack)
		begin
			nxt_q.ack  = 1'b1;
			nxt_q.rdat = reg_read(q_ff, wb_adr);
			if (wb_we)
			begin
				if (wb_adr == ADDR_CTRL)
				begin
					nxt_q.run       = wr_word[CTRL_RUN_BIT];
					nxt_q.pol       = wr_word[CTRL_POL_BIT]; // [R1]
					nxt_q.depth_reg = wr_word[CTRL_DEPTH_LSB +: DEPTH_W]; // [R13]
					nxt_q.bound_reg = wr_word[CTRL_BOUND_BIT]; // [R13]
				end
				else if (wb_adr == ADDR_THR)
				begin
					nxt_q.tmode    = thr_mode_t'(wr_word[THR_MODE_LSB +: 2]);
					nxt_q.op_code  = wr_word[THR_OP_LSB +: 4]; // [R4]
					nxt_q.rel_code = wr_word[THR_REL_LSB +: 4]; // [R4]
				end
				else if (wb_adr == ADDR_STATUS)
				begin
					if (wb_sel[0] && wb_dat_w[ST_WARN_BIT])
						nxt_q.warn = 1'b0;
					if (wb_sel[0] && wb_dat_w[ST_FAIL_BIT])
						nxt_q.fail = 1'b0;
				end
			end
		end

		// Depth and valley style freeze per run so two history lengths never mix
		if (q_ff.run && !q_ff.running)
		begin
			nxt_q.running   = 1'b1;
			nxt_q.act_depth = clamp_depth(q_ff.depth_reg); // [R2] [R13]
			nxt_q.act_bound = q_ff.bound_reg; // [R13]
			nxt_q.phase     = S_VALLEY;
			nxt_q.cur_min   = '1;
			nxt_q.cur_max   = '0;
			nxt_q.valley    = '0;
			nxt_q.vl_valid  = 1'b0;
			nxt_q.pk_valid  = 1'b0;
			pm_clear        = 1'b1;
		end
		else if (!q_ff.run)
			nxt_q.running = 1'b0;
		else if (field_valid)
		begin
			// Only level crossings move the phase, so either rotation reads alike
			if (q_ff.phase == S_VALLEY)
			begin
				if (field_sample < q_ff.cur_min)
					nxt_q.cur_min = field_sample;
				if (field_sample > op_lvl) // [R11]
				begin
					nxt_q.phase   = S_TOOTH;
					nxt_q.cur_max = field_sample;
					if (q_ff.cur_min < field_sample && (!q_ff.act_bound || !q_ff.vl_valid))
						nxt_q.valley = q_ff.cur_min; // [R9]
					else if (q_ff.cur_min < field_sample && jump <= frac(p2p, BOUND_W))
						nxt_q.valley = q_ff.cur_min; // [R10]
					nxt_q.vl_valid = q_ff.vl_valid | (q_ff.cur_min < field_sample);
				end
			end
			else
			begin
				if (field_sample > q_ff.cur_max)
					nxt_q.cur_max = field_sample;
				if (field_sample < rel_lvl) // [R11]
				begin
					nxt_q.phase   = S_VALLEY;
					nxt_q.cur_min = field_sample;
					nxt_q.last_pk = q_ff.cur_max;
					nxt_q.pk_valid = 1'b1;
					pm_push       = 1'b1; // [R6] [R7]
					if (q_ff.pk_valid)
					begin
						set_warn = drop > frac(last_p2p, 12'(op_w - DROP_WARN_W)); // [R5]
						set_fail = drop > frac(last_p2p, 12'(op_w - DROP_FAIL_W)); // [R5]
					end
				end
			end
		end

		// A new drop event outranks a software clear in the same cycle
		nxt_q.warn = nxt_q.warn | set_warn;
		nxt_q.fail = nxt_q.fail | set_fail;

		if (!nxt_q.running)
			nxt_q.out_lvl = 1'b1;
		else if (nxt_q.phase == S_TOOTH)
			nxt_q.out_lvl = q_ff.pol; // [R1]
		else
			nxt_q.out_lvl = !q_ff.pol; // [R1]
		nxt_q.oe = !nxt_q.out_lvl;
	end

	always_ff @(posedge clk or negedge rstn)
	begin
		if (!rstn)
			rst_sync_ff <= 2'h0;
		else
			rst_sync_ff <= {rst_sync_ff[0], 1'b1};
	end

	assign rst_sync_n = rst_sync_ff[1];

	always_ff @(posedge clk or negedge rst_sync_n)
	begin
		if (!rst_sync_n)
			q_ff <= CORE_RST;
		else
			q_ff <= nxt_q;
	end

	assign wb_dat_r      = q_ff.rdat;
	assign wb_ack        = q_ff.ack;
	// The pin is only ever pulled low; the high level comes from the pull-up
	assign target_out    = 1'b0 & q_ff.out_lvl;
	assign target_out_oe = q_ff.oe;

endmodule : cam_threshold_update
`default_nettype wire

// [logic/peak_memory.sv]
// Rotating history of tooth peaks; ref_val is the peak pushed depth teeth ago.
// Assumes depth is 1..DEPTH_MAX_P and only changes together with clear.
`timescale 1ns/10ps
`default_nettype none
module peak_memory
	import cam_thr_pkg::*;
#(
	parameter int W           = SW,
	parameter int DEPTH_MAX_P = DEPTH_MAX
)
(
	input  wire logic clk,
	input  wire logic rst_n,
	peak_mem_if.mem   pm
);

	typedef struct packed {
		logic [DEPTH_MAX_P-1:0][W-1:0] slot;
		logic [DEPTH_W-1:0]            ptr;
		logic [DEPTH_W-1:0]            fill;
		logic [W-1:0]                  last;
	} mem_state_t;

	mem_state_t q_ff;
	mem_state_t nxt_q;

	always_comb
	begin
		nxt_q = q_ff;
		if (pm.clear)
		begin
			nxt_q.ptr  = '0;
			nxt_q.fill = '0;
			nxt_q.last = '0;
		end
		else if (pm.push)
		begin
			nxt_q.slot[q_ff.ptr] = pm.push_val; // [R7]
			if (q_ff.ptr + 4'h1 >= pm.depth)
				nxt_q.ptr = '0;
			else
				nxt_q.ptr = q_ff.ptr + 4'h1;
			if (q_ff.fill < pm.depth)
				nxt_q.fill = q_ff.fill + 4'h1;
			nxt_q.last = pm.push_val;
		end
	end

	// Until n peaks are held the newest one stands in for the missing history
	always_comb
	begin
		if (q_ff.fill >= pm.depth)
			pm.ref_val = q_ff.slot[q_ff.ptr]; // [R8]
		else
			pm.ref_val = q_ff.last; // [R6]
	end

	always_ff @(posedge clk or negedge rst_n)
	begin
		if (!rst_n)
			q_ff <= '0;
		else
			q_ff <= nxt_q;
	end

endmodule : peak_memory
`default_nettype wire

// [pkg/cam_thr_pkg.sv]
// Constants, field layout and types for the camshaft switch-point generator.
// Assumes a 32-bit classic Wishbone register port and an unsigned field sample.
package cam_thr_pkg;

	localparam int SW        = 12;
	localparam int DEPTH_W   = 4;
	localparam int DEPTH_MAX = 12;

	localparam logic [7:0] ADDR_CTRL   = 8'h00;
	localparam logic [7:0] ADDR_THR    = 8'h04;
	localparam logic [7:0] ADDR_STATUS = 8'h08;
	localparam logic [7:0] ADDR_LEVELS = 8'h0C;

	localparam int CTRL_RUN_BIT   = 0;
	localparam int CTRL_POL_BIT   = 1;
	localparam int CTRL_DEPTH_LSB = 2;
	localparam int CTRL_BOUND_BIT = 6;

	localparam int THR_MODE_LSB = 0;
	localparam int THR_OP_LSB   = 4;
	localparam int THR_REL_LSB  = 8;

	localparam int ST_TOOTH_BIT = 0;
	localparam int ST_OUT_BIT   = 1;
	localparam int ST_WARN_BIT  = 2;
	localparam int ST_FAIL_BIT  = 3;
	localparam int ST_RUN_BIT   = 4;

	localparam int LV_PEAK_LSB   = 0;
	localparam int LV_VALLEY_LSB = 16;

	localparam logic [3:0] DEPTH_RST = 4'h1;
	localparam logic [3:0] CODE_RST  = 4'h0;

	// Percentages are held in units of 1/64 percent, so 1.5625 % is exactly 100
	localparam int         PCT_SCALE   = 6400;
	localparam logic [11:0] PCT_30     = 12'h780;
	localparam logic [11:0] PCT_50     = 12'hC80;
	localparam logic [11:0] PCT_STEP   = 12'h064;
	localparam logic [3:0]  CODE_MAX   = 4'hC;
	localparam logic [11:0] HYS_W      = 12'h280;
	localparam logic [11:0] DROP_WARN_W = 12'h3C0;
	localparam logic [11:0] DROP_FAIL_W = 12'h140;
	localparam logic [11:0] BOUND_W    = 12'h640;

	typedef enum logic [1:0] {THR_STD30, THR_STD50, THR_CUSTOM} thr_mode_t;
	typedef enum logic {S_VALLEY, S_TOOTH} phase_t;

endpackage : cam_thr_pkg

// [pkg/peak_mem_if.sv]
// Link between the switch-point core and its tooth peak history.
// Assumes both ends run on the same clock.
`timescale 1ns/10ps
`default_nettype none
interface peak_mem_if #(parameter int W = 12, parameter int DW = 4);
	logic          clear;
	logic          push;
	logic [W-1:0]  push_val;
	logic [DW-1:0] depth;
	logic [W-1:0]  ref_val;

	modport core (output clear, output push, output push_val, output depth, input ref_val);
	modport mem  (input clear, input push, input push_val, input depth, output ref_val);
endinterface : peak_mem_if
`default_nettype wire

// [testbench/cam_thr_asserts.sv]
// Port-level checks for the switch-point generator.
// Assumes it is bound to cam_threshold_update and sees only its ports.
`timescale 1ns/10ps
`default_nettype none
module cam_thr_asserts
	import cam_thr_pkg::*;
(
	input wire logic        clk,
	input wire logic        rstn,
	input wire logic        wb_cyc,
	input wire logic        wb_stb,
	input wire logic        wb_we,
	input wire logic [7:0]  wb_adr,
	input wire logic [3:0]  wb_sel,
	input wire logic [31:0] wb_dat_w,
	input wire logic [31:0] wb_dat_r,
	input wire logic        wb_ack,
	input wire logic        field_valid,
	input wire logic        target_out,
	input wire logic        target_out_oe
);
	default clocking cb @(posedge clk); endclocking
	default disable iff (!rstn);
	logic req;
	logic stop;
	assign req  = wb_cyc && wb_stb && !wb_ack;
	assign stop = req && wb_we && wb_adr == ADDR_CTRL && wb_sel[0] && !wb_dat_w[CTRL_RUN_BIT];
	chk_ack_latency:
		assert property (req |=> wb_ack) else $error("ack missing after request");
	chk_ack_single:
		assert property (wb_ack |=> !wb_ack) else $error("ack held too long");
	chk_ack_cause:
		assert property (!(wb_cyc && wb_stb) |=> !wb_ack) else $error("ack without request");
	chk_unmapped_zero:
		assert property (req && !wb_we && wb_adr > 8'h0F |=> wb_dat_r == 32'h0000_0000)
		else $error("unmapped read not zero");
	chk_read_hold:
		assert property (!req |=> $stable(wb_dat_r)) else $error("read data moved while idle");
	chk_drain_only:
		assert property (target_out == 1'b0) else $error("pin driven high");
	chk_oe_quiet:
		assert property (!field_valid && !wb_cyc && !$past(wb_cyc) && !$past(wb_cyc, 2)
			|=> $stable(target_out_oe)) else $error("output moved without cause");
	chk_stop_release:
		assert property (stop |-> ##[1:3] !target_out_oe) else $error("pin not released");
	cov_write: cover property (req && wb_we);
	cov_pull: cover property (field_valid ##1 $rose(target_out_oe));
	cov_free: cover property (field_valid ##1 $fell(target_out_oe));
endmodule : cam_thr_asserts
bind cam_threshold_update cam_thr_asserts cam_thr_asserts_inst (.clk(clk), .rstn(rstn),
	.wb_cyc(wb_cyc), .wb_stb(wb_stb), .wb_we(wb_we), .wb_adr(wb_adr), .wb_sel(wb_sel),
	.wb_dat_w(wb_dat_w), .wb_dat_r(wb_dat_r), .wb_ack(wb_ack), .field_valid(field_valid),
	.target_out(target_out), .target_out_oe(target_out_oe));
`default_nettype wire

// [testbench/ecu_input_model.sv]
// Engine controller input: reads the open-drain sensor line through a pull-up.
// Assumes the sensor only ever pulls the line low.
`timescale 1ns/10ps
`default_nettype none
module ecu_input_model
(
	input  wire logic target_out,
	input  wire logic target_out_oe,
	output var  logic pin
);
	// Released line floats up to the pull-up level, never to the last driven value
	assign pin = target_out_oe ? target_out : 1'b1;
endmodule : ecu_input_model
`default_nettype wire

// [testbench/tb_top.sv]
// Self-checking bench: registers over Wishbone, tooth/valley stimulus, pin checks.
// Assumes the design answers every access and pulls the pin only through oe.
`timescale 1ns/10ps
`default_nettype none
module tb_top
	import cam_thr_pkg::*;
;
	localparam int VAL = 100;
	localparam int PK  = 3100;
	logic        clk = 0, rstn = 0, wb_cyc = 0, wb_stb = 0, wb_we = 0, field_valid = 0;
	logic [7:0]  wb_adr = 0;
	logic [3:0]  wb_sel = 0;
	logic [31:0] wb_dat_w = 0, wb_dat_r, q, v;
	logic [11:0] field_sample = 0, pk, op, rl;
	logic        wb_ack, target_out, target_out_oe, pin, pol;
	int          fails = 0, checks = 0, n, r, t, i, seed;
	int          h[$];
	always #5 clk = ~clk;
	cam_threshold_update cam_threshold_update_inst (.clk(clk), .rstn(rstn), .wb_cyc(wb_cyc),
		.wb_stb(wb_stb), .wb_we(wb_we), .wb_adr(wb_adr), .wb_sel(wb_sel), .wb_dat_w(wb_dat_w),
		.wb_dat_r(wb_dat_r), .wb_ack(wb_ack), .field_sample(field_sample),
		.field_valid(field_valid), .target_out(target_out), .target_out_oe(target_out_oe));
	ecu_input_model ecu_input_model_inst (.target_out(target_out),
		.target_out_oe(target_out_oe), .pin(pin));
	task automatic final_report;
		$display("checks %0d fails %0d", checks, fails);
		if (fails == 0 && checks > 0)
			$display("Finished cleanly");
		else
			$display("Finished with errors");
		$finish;
	endtask : final_report
	task automatic cmp(input string nm, input logic [31:0] e, input logic [31:0] g);
		checks++;
		if (g !== e)
		begin
			fails++;
			$display("[ERR] %s expected %h seen %h", nm, e, g);
		end
	endtask : cmp
	task automatic acc(input logic [7:0] a, input logic we, input logic [31:0] d);
		int k;
		@(posedge clk);
		wb_cyc <= 1'b1;
		wb_stb <= 1'b1;
		wb_we <= we;
		wb_adr <= a;
		wb_sel <= 4'hF;
		wb_dat_w <= d;
		k = 0;
		do
		begin
			@(posedge clk);
			k++;
		end
		while (wb_ack !== 1'b1 && k < 20);
		q = wb_dat_r;
		wb_cyc <= 1'b0;
		wb_stb <= 1'b0;
		@(posedge clk);
		if (k >= 20)
		begin
			fails++;
			final_report();
		end
	endtask : acc
	task automatic smp(input logic [11:0] s, input logic tooth, input logic en);
		@(posedge clk);
		field_sample <= s;
		field_valid <= 1'b1;
		@(posedge clk);
		field_valid <= 1'b0;
		@(posedge clk);
		if (en)
			cmp("pin", {31'h0, ~(tooth ^ pol)}, {31'h0, pin});
	endtask : smp
	function automatic logic [11:0] lvl(input logic up, input logic [1:0] m, input logic [3:0] c);
		int w;
		int hy;
		w = (m == 2'd1 || (m == 2'd2 && c > CODE_MAX)) ? int'(PCT_50) :
			(m == 2'd2 ? int'(PCT_30) + int'(c) * int'(PCT_STEP) : int'(PCT_30));
		hy = (PK - VAL) * int'(HYS_W) / PCT_SCALE / 2;
		return 12'(VAL + (PK - VAL) * w / PCT_SCALE + (up ? hy : -hy));
	endfunction : lvl
	initial
	begin
		seed = $urandom(65566);
		repeat (20) @(posedge clk);
		rstn <= 1'b1;
		repeat (3) @(posedge clk);
		acc(ADDR_CTRL, 0, 0);
		cmp("ctrl", 32'h0000_0004, q);
		acc(ADDR_THR, 0, 0);
		cmp("thr", 32'h0000_0000, q);
		acc(8'h10, 1, 32'hFFFF_FFFF);
		acc(8'h3C, 0, 0);
		cmp("unmapped", 32'h0000_0000, q);
		v = $urandom & 32'h0000_007E;
		acc(ADDR_CTRL, 1, v);
		acc(ADDR_CTRL, 0, 0);
		cmp("ctrl", v, q);
		cmp("pin idle", 32'h0000_0001, {31'h0, pin});
		$display("register test done");
		for (r = 0; r < 4; r++)
		begin
			n = r == 0 ? 1 : (r == 1 ? 3 : (r == 2 ? 12 : 15));
			pol = r[0];
			acc(ADDR_CTRL, 1, 0);
			acc(ADDR_CTRL, 1, 32'(1 + (pol << 1) + (n << 2) + (r[1] << 6)));
			n = n > DEPTH_MAX ? DEPTH_MAX : n;
			h.delete();
			for (t = 0; t < 16; t++)
			begin
				pk = 12'(2800 + $urandom % 400);
				smp(pk, 1, t > 1);
				v = 2800 + $urandom % 400;
				smp(v[11:0], 1, t > 1);
				h.push_back(v > pk ? int'(v) : int'(pk));
				smp(12'(VAL + $urandom % 200), 0, t > 1);
				acc(ADDR_LEVELS, 0, 0);
				if (t > 1)
					cmp("ref peak", h.size() >= n ? h[h.size() - n] : h[$], q[11:0]);
				smp(12'(VAL + $urandom % 200), 0, t > 1);
			end
			$display("depth %0d test done", n);
		end
		for (r = 0; r < 2; r++)
		begin
			pol = r[0];
			acc(ADDR_CTRL, 1, 0);
			acc(ADDR_THR, 1, 0);
			acc(ADDR_CTRL, 1, 32'(5 + (pol << 1)));
			repeat (3)
			begin
				smp(12'(VAL), 0, 0);
				smp(12'(PK), 1, 0);
			end
			smp(12'(VAL), 0, 1);
			acc(ADDR_STATUS, 1, 32'h0000_000C);
			for (i = 0; i < 6; i++)
			begin
				v[1:0] = i == 5 ? 2'd3 : (i < 2 ? 2'(i) : 2'd2);
				v[7:4] = i == 2 ? 4'h0 : (i == 3 ? 4'hF : 4'($urandom % 13));
				v[11:8] = 4'($urandom % 16);
				acc(ADDR_THR, 1, {20'h0, v[11:4], 2'b00, v[1:0]});
				op = lvl(1, v[1:0], v[7:4]);
				rl = lvl(0, v[1:0], v[11:8]);
				smp(op, 0, 1);
				smp(op + 12'h001, 1, 1);
				smp(12'(PK), 1, 1);
				smp(rl, 1, 1);
				smp(rl - 12'h001, 0, 1);
				smp(12'(VAL), 0, 1);
			end
			acc(ADDR_LEVELS, 0, 0);
			cmp("valley", VAL, q[27:16]);
			acc(ADDR_STATUS, 0, 0);
			cmp("status", 32'h0000_0010, q & 32'h0000_001C);
			// Peak falls by 600 of 3000: past the 15 % warn bound, short of the 25 % fail bound
			smp(12'(PK - 600), 1, 1);
			smp(12'(VAL), 0, 1);
			acc(ADDR_STATUS, 0, 0);
			cmp("status drop", 32'h0000_0014, q & 32'h0000_001C);
			$display("threshold test done");
		end
		final_report();
	end
endmodule : tb_top
`default_nettype wire
